/* verilog/otp_access_ctrl.sv */
/*
 Secured OTP access control behind the serial flash pins: command framing,
 OTP mode, security flags and the OTP array.
 Assumes serial clock well below a quarter of clk; pins are asynchronous.
*/
`timescale 1ns/100ps
// Function
// - Opcode B1h switches later accesses into the separate 4 kbit OTP region.
// - Opcode C1h leaves OTP mode and returns accesses to the main array.
// - In OTP mode, read and page program act on the OTP region.
// - In OTP mode, status writes and security writes are refused.
// - Once the OTP is locked, only reads work; program and erase ignored.
// - Opcode 2Bh returns the security flags anytime, repeating while clocked.
// - Flag bit 0 is the non-volatile factory lock indicator.
// - Flag bit 1 is the customer lock, settable by the security write.
// - With customer lock set, neither the flag nor OTP data may change.
// - In OTP mode, every main array write is blocked.
// - Security write 2Fh needs no write-enable latch.
// - Security write executes only if chip select rises on a byte boundary.
// - OTP 000000-00000F is the serial number; 000010-0001FF user area.
// - Enter and exit work in single-wire and quad framing.
module otp_access_ctrl (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic sclk_pin,
   input wire logic cs_n_pin,
   input wire logic [3:0] io_pin_in,
   input wire logic factory_lock_strap,
   input wire logic quad_command_framing,
   output logic [3:0] io_out,
   output logic [3:0] io_oe,
   output logic otp_mode,
   output logic array_write_block,
   output logic otp_locked,
   output logic status_write_refused,
   output logic cmd_refused,
   output logic serial_number_hit
);
   import otp_access_pkg::*;

   function automatic logic [1:0] region_of(input logic [23:0] a);
      if (a <= SN_LAST) begin
         region_of = REGION_SN;
      end else if (a <= USER_LAST) begin
         region_of = REGION_USER;
      end else begin
         region_of = REGION_NONE;
      end
   endfunction

   // ****************************************
   // Pin synchronisation and edges
   // ****************************************
   logic [6:0] pins;
   logic sclk_d, cs_d, rise, fall, cs_end;
   pin_sync #(.W(7), .RST_VAL(PIN_RST_VAL)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in({factory_lock_strap, sclk_pin, cs_n_pin, io_pin_in}),
      .sync_out(pins)
   );
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sclk_d <= 1'b0;
         cs_d <= 1'b1;
      end else begin
         sclk_d <= pins[5];
         cs_d <= pins[4];
      end
   end
   assign rise = pins[5] & ~sclk_d & ~pins[4];
   assign fall = ~pins[5] & sclk_d & ~pins[4];
   assign cs_end = pins[4] & ~cs_d;

   // ****************************************
   // Bit and byte assembly
   // ****************************************
   frame_e state;
   logic [7:0] sh, cmd, next_rx;
   logic [2:0] bib, nbytes;
   logic [3:0] step, sum;
   logic byte_done;
   logic [23:0] addr;
   always_comb begin
      step = quad_command_framing ? STEP_QUAD : STEP_SINGLE;
      sum = {1'b0, bib} + step;
      byte_done = rise & sum[3];
      next_rx = quad_command_framing ? {sh[3:0], pins[3:0]} : {sh[6:0], pins[0]};
   end
   always_ff @(posedge clk) begin
      if (sys_rst || cs_end || state == ST_IDLE) begin
         sh <= 8'h00;
         bib <= 3'h0;
         nbytes <= 3'h0;
      end else if (rise) begin
         sh <= next_rx;
         bib <= sum[2:0];
         if (byte_done && nbytes != BYTE_CNT_MAX) begin
            nbytes <= nbytes + 3'h1;
         end
      end
   end

   // ****************************************
   // Frame state
   // ****************************************
   logic factory_lock, customer_lock, locked, wel;
   always_comb locked = factory_lock | customer_lock;
   always_ff @(posedge clk) begin
      if (sys_rst || cs_end) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: if (!pins[4]) state <= ST_CMD;
            ST_CMD: if (byte_done) begin
               if ((next_rx == OP_READ || next_rx == OP_PROGRAM) && otp_mode) begin
                  state <= ST_ADDR;
               end else if (next_rx == OP_SEC_READ || next_rx == OP_SEC_WRITE) begin
                  state <= ST_DATA;
               end else begin
                  state <= ST_SKIP;
               end
            end
            ST_ADDR: if (byte_done && nbytes == ADDR_BYTES) state <= ST_DATA;
            ST_DATA: state <= ST_DATA;
            default: state <= ST_SKIP;
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmd <= 8'h00;
      end else if (state == ST_CMD && byte_done) begin
         cmd <= next_rx;
      end
   end
   // Address doubles as the byte pointer, stepped after every data byte
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         addr <= 24'h000000;
      end else if (state == ST_ADDR && byte_done) begin
         addr <= {addr[15:0], next_rx};
      end else if (state == ST_DATA && byte_done) begin
         addr <= addr + 24'h000001;
      end
   end

   // ****************************************
   // Mode, latches and flags
   // ****************************************
   logic cmd_hit;
   logic [7:0] last_byte;
   logic [1:0] strap_cnt;
   logic sec_ok;
   assign cmd_hit = state == ST_CMD && byte_done;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         otp_mode <= 1'b0;
         array_write_block <= 1'b0;
      end else if (cmd_hit && next_rx == OP_OTP_ENTER) begin
         otp_mode <= 1'b1;
         array_write_block <= 1'b1;
      end else if (cmd_hit && next_rx == OP_OTP_EXIT) begin
         otp_mode <= 1'b0;
         array_write_block <= 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wel <= 1'b0;
      end else if (cmd_hit && next_rx == OP_WREN) begin
         wel <= 1'b1;
      end else if ((cmd_hit && next_rx == OP_WRDI) || (cs_end && cmd == OP_PROGRAM)) begin
         wel <= 1'b0;
      end
   end
   // Strap is caught once the synchroniser has settled after reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         strap_cnt <= 2'h0;
         factory_lock <= 1'b0;
      end else if (strap_cnt != STRAP_SETTLE) begin
         strap_cnt <= strap_cnt + 2'h1;
         factory_lock <= pins[6];
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         last_byte <= 8'h00;
      end else if (byte_done) begin
         last_byte <= next_rx;
      end
   end
   // No write-enable check; a ragged frame end discards the command
   assign sec_ok = cmd == OP_SEC_WRITE && nbytes == SEC_WRITE_BYTES && bib == 3'h0
      && !otp_mode && !customer_lock;
   // Held in flops here; the cell behind it keeps it across power cycles
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         customer_lock <= 1'b0;
      end else if (cs_end && sec_ok && last_byte[SEC_CUSTOMER_BIT]) begin
         customer_lock <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         otp_locked <= 1'b0;
      end else begin
         otp_locked <= locked;
      end
   end

   // ****************************************
   // Refusal pulses
   // ****************************************
   logic is_erase;
   assign is_erase = next_rx == OP_ERASE_4K || next_rx == OP_ERASE_32K
      || next_rx == OP_ERASE_64K || next_rx == OP_ERASE_CHIP1 || next_rx == OP_ERASE_CHIP2;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status_write_refused <= 1'b0;
         cmd_refused <= 1'b0;
      end else begin
         status_write_refused <= cmd_hit && otp_mode && (next_rx == OP_STAT_WRITE1
            || next_rx == OP_STAT_WRITE2 || next_rx == OP_SEC_WRITE);
         cmd_refused <= cmd_hit && otp_mode && (is_erase
            || (next_rx == OP_PROGRAM && (locked || !wel)));
      end
   end

   // ****************************************
   // OTP array access
   // ****************************************
   logic mem_we;
   logic [7:0] mem_rdata, rd_val;
   assign mem_we = state == ST_DATA && byte_done && cmd == OP_PROGRAM && otp_mode && wel
      && !locked && region_of(addr) != REGION_NONE;
   otp_mem #(.AW(OTP_AW), .DW(OTP_DW)) u_mem (
      .clk(clk),
      .we(mem_we),
      .waddr(addr[OTP_AW-1:0]),
      .wdata(next_rx),
      .raddr(addr[OTP_AW-1:0]),
      .rdata(mem_rdata)
   );
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         serial_number_hit <= 1'b0;
      end else begin
         serial_number_hit <= state == ST_DATA && otp_mode && region_of(addr) == REGION_SN
            && (cmd == OP_READ || cmd == OP_PROGRAM);
      end
   end

   // ****************************************
   // Read data out
   // ****************************************
   logic load_pend;
   logic [7:0] tx_sh, tx_val;
   always_comb begin
      if (cmd == OP_SEC_READ) begin
         tx_val = {SEC_RESERVED_VAL, customer_lock, factory_lock};
      end else if (region_of(addr) == REGION_NONE) begin
         tx_val = BLANK_BYTE;
      end else begin
         tx_val = mem_rdata;
      end
   end
   // Loading on the falling edge gives the array read a half period to settle
   always_ff @(posedge clk) begin
      if (sys_rst || cs_end) begin
         load_pend <= 1'b0;
      end else if ((state == ST_ADDR && byte_done && nbytes == ADDR_BYTES && cmd == OP_READ)
            || (cmd_hit && next_rx == OP_SEC_READ)
            || (state == ST_DATA && byte_done && (cmd == OP_READ || cmd == OP_SEC_READ))) begin
         load_pend <= 1'b1;
      end else if (fall) begin
         load_pend <= 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst || cs_end) begin
         tx_sh <= 8'h00;
         io_out <= 4'h0;
         io_oe <= 4'h0;
      end else if (fall && load_pend) begin
         tx_sh <= quad_command_framing ? {tx_val[3:0], 4'h0} : {tx_val[6:0], 1'b0};
         io_out <= quad_command_framing ? tx_val[7:4] : {2'b00, tx_val[7], 1'b0};
         io_oe <= quad_command_framing ? OE_QUAD : OE_SINGLE;
      end else if (fall && io_oe != 4'h0) begin
         tx_sh <= quad_command_framing ? {tx_sh[3:0], 4'h0} : {tx_sh[6:0], 1'b0};
         io_out <= quad_command_framing ? tx_sh[7:4] : {2'b00, tx_sh[7], 1'b0};
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence seq_enter;
      cmd_hit && next_rx == OP_OTP_ENTER;
   endsequence
   sequence seq_exit;
      cmd_hit && next_rx == OP_OTP_EXIT && !(next_rx == OP_OTP_ENTER);
   endsequence
   AST_ENTER: assert property (seq_enter |=> otp_mode && array_write_block)
      else $error("otp mode not entered");
   AST_EXIT: assert property (seq_exit |=> !otp_mode ##1 !array_write_block)
      else $error("otp mode not left");
   AST_BLOCK: assert property (otp_mode == array_write_block)
      else $error("array write block disagrees with otp mode");
   AST_SR_REFUSE: assert property (cmd_hit && otp_mode && next_rx == OP_STAT_WRITE1
      |=> status_write_refused ##1 !status_write_refused)
      else $error("status write not refused");
   AST_LOCK_STICKY: assert property (customer_lock |=> customer_lock)
      else $error("customer lock cleared");
   AST_NO_PROG_LOCKED: assert property (mem_we |-> !customer_lock && !factory_lock)
      else $error("locked otp written");
   AST_LOCK_CAUSE: assert property ($rose(customer_lock) |-> $past(cs_end)
      && $past(cmd) == OP_SEC_WRITE && $past(bib) == 3'h0 && !$past(otp_mode))
      else $error("lock set without a clean write frame");
   // Reserved msb leaves first; the two flags wait in the shifter
   AST_FLAGS: assert property (fall && load_pend && cmd == OP_SEC_READ
      && !quad_command_framing |=> io_out[1] == SEC_RESERVED_VAL[5]
      && tx_sh[2:1] == {customer_lock, factory_lock} && io_oe == OE_SINGLE ##1 !fall [*1])
      else $error("security flags not driven");
   AST_RANGE: assert property (mem_we |-> addr <= USER_LAST)
      else $error("write outside otp range");
endmodule // otp_access_ctrl

/* common/otp_access_pkg.sv */
/*
 Shared constants for the secured OTP access block: opcodes, OTP map,
 security flag layout, framing steps and frame states.
 Assumes one 100 MHz system clock and a host that frames commands with chip select.
*/
package otp_access_pkg;
   // ****************************************
   // Opcodes
   // ****************************************
   localparam logic [7:0] OP_OTP_ENTER = 8'hB1;
   localparam logic [7:0] OP_OTP_EXIT = 8'hC1;
   localparam logic [7:0] OP_SEC_READ = 8'h2B;
   localparam logic [7:0] OP_SEC_WRITE = 8'h2F;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_PROGRAM = 8'h02;
   localparam logic [7:0] OP_STAT_WRITE1 = 8'h01;
   localparam logic [7:0] OP_STAT_WRITE2 = 8'h31;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_ERASE_4K = 8'h20;
   localparam logic [7:0] OP_ERASE_32K = 8'h52;
   localparam logic [7:0] OP_ERASE_64K = 8'hD8;
   localparam logic [7:0] OP_ERASE_CHIP1 = 8'hC7;
   localparam logic [7:0] OP_ERASE_CHIP2 = 8'h60;
   // ****************************************
   // OTP map and security flags
   // ****************************************
   localparam int OTP_AW = 9;
   localparam int OTP_DW = 8;
   localparam logic [23:0] SN_LAST = 24'h00000F;
   localparam logic [23:0] USER_LAST = 24'h0001FF;
   localparam logic [1:0] REGION_SN = 2'h0;
   localparam logic [1:0] REGION_USER = 2'h1;
   localparam logic [1:0] REGION_NONE = 2'h2;
   localparam int SEC_FACTORY_BIT = 0;
   localparam int SEC_CUSTOMER_BIT = 1;
   localparam logic [5:0] SEC_RESERVED_VAL = 6'h00;
   localparam logic [7:0] BLANK_BYTE = 8'hFF;
   // ****************************************
   // Framing and timing
   // ****************************************
   localparam logic [3:0] STEP_SINGLE = 4'h1;
   localparam logic [3:0] STEP_QUAD = 4'h4;
   localparam logic [3:0] OE_SINGLE = 4'h2;
   localparam logic [3:0] OE_QUAD = 4'hF;
   localparam logic [2:0] ADDR_BYTES = 3'h3;
   localparam logic [2:0] SEC_WRITE_BYTES = 3'h2;
   localparam logic [2:0] BYTE_CNT_MAX = 3'h7;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;
   localparam logic [6:0] PIN_RST_VAL = 7'h10;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CMD = 3'b001,
      ST_ADDR = 3'b010,
      ST_DATA = 3'b011,
      ST_SKIP = 3'b100
   } frame_e;
endpackage

/* verilog/pin_sync.sv */
/*
 Two-stage synchroniser for a bundle of pin levels.
 Assumes each bit is an independent slow level; no bus coherency is implied.
*/
`timescale 1ns/100ps
module pin_sync #(
   parameter int W = 7,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta;
   // ****************************************
   // Stages
   // ****************************************
   // First stage feeds only the second stage
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            meta[i] <= RST_VAL[i];
            sync_out[i] <= RST_VAL[i];
         end else begin
            meta[i] <= async_in[i];
            sync_out[i] <= meta[i];
         end
      end
   end
endmodule // pin_sync

/* verilog/otp_mem.sv */
/*
 OTP storage array, one write port and one registered read port.
 Assumes the caller gates writes; the array itself has no reset.
*/
`timescale 1ns/100ps
module otp_mem #(
   parameter int AW = 9,
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];
   // ****************************************
   // Array
   // ****************************************
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // otp_mem

/* bench/flash_host_model.sv */
/*
 Serial flash host controller model: frames commands with chip select,
 drives mode 0 serial clock, shifts single-wire or quad data.
 Assumes the device drives read data well before the next clock rise.
*/
`timescale 1ns/100ps
module flash_host_model #(
   parameter int HALF = 8,
   parameter int GAP = 8,
   parameter int PUW = 200
) (
   input wire logic clk,
   input wire logic quad,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe,
   output logic sclk_pin,
   output logic cs_n_pin,
   output logic [3:0] io_pin_in
);
   logic [3:0] drv;
   initial begin
      sclk_pin = 1'b0;
      cs_n_pin = 1'b1;
      drv = 4'h0;
   end
   // Wire level: device wins where it enables its driver
   assign io_pin_in = (io_oe & io_out) | (~io_oe & drv);
   // ****************************************
   // Host tasks
   // ****************************************
   // Short stand-in for the power-up write delay, kept short for run time
   task automatic power_up();
      repeat (PUW) @(posedge clk);
   endtask
   // Serial clock stands still low outside frames
   task automatic xfer(input logic [63:0] tx, input int nb, input int nr,
         output logic [63:0] rx);
      int st;
      rx = '0;
      @(posedge clk);
      st = quad ? 4 : 1;
      cs_n_pin <= 1'b0;
      for (int i = 0; i < nb + nr; i += st) begin
         // Released lines flip every step so a stale level never looks valid
         drv <= (i < nb) ? (quad ? tx[63:60] : {~drv[3:1], tx[63]}) : ~drv;
         tx = tx << st;
         repeat (HALF) @(posedge clk);
         if (i >= nb) rx = quad ? {rx[59:0], io_pin_in} : {rx[62:0], io_pin_in[1]};
         sclk_pin <= 1'b1;
         repeat (HALF) @(posedge clk);
         sclk_pin <= 1'b0;
      end
      repeat (HALF) @(posedge clk);
      cs_n_pin <= 1'b1;
      repeat (GAP) @(posedge clk);
   endtask
endmodule // flash_host_model

/* bench/test_secured_otp_access_control.sv */
/*
 Self-checking bench for the OTP access block, with the host model
 driving its pins. Assumes a 100 MHz clock and synchronous reset.
*/
`timescale 1ns/100ps
module test_secured_otp_access_control;
   import otp_access_pkg::*;
   logic clk, sys_rst, strap, quad, sclk_pin, cs_n_pin, sn_seen;
   logic [3:0] io_pin_in, io_out, io_oe;
   logic otp_mode, array_write_block, otp_locked, status_write_refused, cmd_refused;
   logic serial_number_hit;
   logic [63:0] rx;
   logic [23:0] a_sn, a_user;
   logic [7:0] d_sn, d_user;
   logic [7:0] erase_ops [5] = '{OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K,
      OP_ERASE_CHIP1, OP_ERASE_CHIP2};
   int n_errors, n_checks, n_swr, n_cref, cycles, seed, k;
   otp_access_ctrl otp_access_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .sclk_pin(sclk_pin),
      .cs_n_pin(cs_n_pin), .io_pin_in(io_pin_in), .factory_lock_strap(strap),
      .quad_command_framing(quad), .io_out(io_out), .io_oe(io_oe), .otp_mode(otp_mode),
      .array_write_block(array_write_block), .otp_locked(otp_locked),
      .status_write_refused(status_write_refused), .cmd_refused(cmd_refused),
      .serial_number_hit(serial_number_hit));
   flash_host_model flash_host_model_inst (.clk(clk), .quad(quad), .io_out(io_out),
      .io_oe(io_oe), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .io_pin_in(io_pin_in));
   // ****************************************
   // Clock, monitor and helpers
   // ****************************************
   initial clk = 1'b0;
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (status_write_refused === 1'b1) n_swr++;
      if (cmd_refused === 1'b1) n_cref++;
      if (serial_number_hit === 1'b1) sn_seen = 1'b1;
      if (cycles == 40000) begin
         n_errors++;
         report_and_stop();
      end
   end
   function automatic logic [7:0] sec_exp(input logic cust, input logic fact);
      return {SEC_RESERVED_VAL, cust, fact};
   endfunction
   task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         n_errors++;
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic do_reset(input logic s);
      @(posedge clk);
      sys_rst <= 1'b1;
      strap <= s;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   task automatic op(input logic [7:0] c);
      flash_host_model_inst.xfer({c, 56'h0}, 8, 0, rx);
   endtask
   task automatic sec_write(input logic [7:0] d, input int nb);
      flash_host_model_inst.xfer({OP_SEC_WRITE, d, 48'h0}, nb, 0, rx);
   endtask
   // Two bytes read back to back show the register repeats
   task automatic sec_read(input logic [7:0] e);
      flash_host_model_inst.xfer({OP_SEC_READ, 56'h0}, 8, 16, rx);
      check("security flags", {2{e}}, rx[15:0]);
   endtask
   task automatic prog(input logic [23:0] a, input logic [7:0] d);
      op(OP_WREN);
      flash_host_model_inst.xfer({OP_PROGRAM, a, d, 24'h0}, 40, 0, rx);
   endtask
   task automatic rd(input logic [23:0] a, input logic [7:0] e, input logic hit);
      sn_seen = 1'b0;
      flash_host_model_inst.xfer({OP_READ, a, 32'h0}, 32, 8, rx);
      check("otp read data", e, rx[7:0]);
      check("serial number hit", hit, sn_seen);
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      seed = 32'h5d31;
      sys_rst = 1'b1;
      strap = 1'b0;
      quad = 1'b0;
      sn_seen = 1'b0;
      n_errors = 0;
      n_checks = 0;
      n_swr = 0;
      n_cref = 0;
      cycles = 0;
      do_reset(1'b0);
      flash_host_model_inst.power_up();
      check("mode after reset", 0, otp_mode);
      sec_read(sec_exp(1'b0, 1'b0));
      for (int q = 0; q < 2; q++) begin
         quad <= q[0];
         op(OP_OTP_ENTER);
         check("mode on entry", 1, otp_mode);
         check("array write block", 1, array_write_block);
         sec_read(sec_exp(1'b0, 1'b0));
         op(OP_OTP_EXIT);
         check("mode on exit", 0, otp_mode);
         check("array write free", 0, array_write_block);
      end
      quad <= 1'b0;
      $display("test framing done");
      op(OP_OTP_ENTER);
      k = n_swr;
      op(OP_STAT_WRITE1);
      op(OP_STAT_WRITE2);
      sec_write(8'h02, 16);
      check("status write refusals", k + 3, n_swr);
      check("lock kept", 0, otp_locked);
      k = n_cref;
      foreach (erase_ops[i]) op(erase_ops[i]);
      check("erase refusals", k + 5, n_cref);
      $display("test refusals done");
      a_sn = 24'($unsigned($random(seed)) % 16);
      a_user = 24'h000010 + 24'($unsigned($random(seed)) % 496);
      d_sn = 8'($random(seed));
      d_user = 8'($random(seed));
      prog(a_sn, d_sn);
      prog(a_user, d_user);
      k = n_cref;
      op(OP_WREN);
      op(OP_WRDI);
      flash_host_model_inst.xfer({OP_PROGRAM, a_user, ~d_user, 24'h0}, 40, 0, rx);
      check("program without latch", k + 1, n_cref);
      rd(a_sn, d_sn, 1'b1);
      rd(a_user, d_user, 1'b0);
      rd(24'h000200, BLANK_BYTE, 1'b0);
      op(OP_OTP_EXIT);
      $display("test program done");
      sec_write(8'h02, 17);
      check("ragged write ignored", 0, otp_locked);
      sec_write(8'hFE, 16);
      check("customer lock set", 1, otp_locked);
      sec_read(sec_exp(1'b1, 1'b0));
      op(OP_OTP_ENTER);
      k = n_cref;
      prog(a_user, ~d_user);
      check("locked program refused", k + 1, n_cref);
      rd(a_user, d_user, 1'b0);
      op(OP_OTP_EXIT);
      sec_write(8'h00, 16);
      sec_read(sec_exp(1'b1, 1'b0));
      $display("test customer lock done");
      do_reset(1'b1);
      sec_read(sec_exp(1'b0, 1'b1));
      check("factory lock", 1, otp_locked);
      op(OP_OTP_ENTER);
      k = n_cref;
      prog(a_sn, ~d_sn);
      check("factory locked program", k + 1, n_cref);
      $display("test factory lock done");
      report_and_stop();
   end
endmodule // test_secured_otp_access_control
